// ---- infoframe_register_bank.v ----
// read-only bank of received video and audio information frame fields
`timescale 1ns/1ps
`include "infoframe_regs.vh"
module infoframe_register_bank (
  input  wire        I_CLOCK,
  input  wire        I_ARST_N,
  // host register read port
  input  wire        I_RD_STROBE,
  input  wire [7:0]  I_RD_ADDR,
  // frame byte updates from the packet parser
  input  wire        I_PKT_WR,
  input  wire [7:0]  I_PKT_ADDR,
  input  wire [7:0]  I_PKT_DATA,
  input  wire [2:0]  I_PKT_KIND,
  input  wire [6:0]  I_EXT_CHANGE,
  // display geometry for the bar decisions
  input  wire [15:0] I_DISPLAY_LINES,
  input  wire [15:0] I_DISPLAY_PIXELS,
  // read answer
  output reg  [7:0]  O_RD_DATA,
  output reg         O_RD_VALID,
  // decoded fields
  output reg  [6:0]  O_NEW_DATA_FLAGS,
  output reg  [1:0]  O_ASPECT_CODE,
  output reg  [3:0]  O_ACTIVE_FORMAT_CODE,
  output reg  [1:0]  O_SCALING_CODE,
  output reg  [6:0]  O_VIDEO_FORMAT_CODE,
  output reg  [4:0]  O_PIXEL_SEND_COUNT,
  output reg  [15:0] O_TOP_BAR_END,
  output reg  [15:0] O_BOTTOM_BAR_START,
  output reg  [15:0] O_LEFT_BAR_END,
  output reg  [15:0] O_RIGHT_BAR_START,
  output reg         O_TOP_BAR_PRESENT,
  output reg         O_BOTTOM_BAR_PRESENT,
  output reg         O_LEFT_BAR_PRESENT,
  output reg         O_RIGHT_BAR_PRESENT,
  output reg  [3:0]  O_AUDIO_CODING_CODE,
  output reg  [3:0]  O_CHANNEL_COUNT,
  output reg  [10:0] O_MAX_BIT_RATE_KHZ,
  output reg  [7:0]  O_SPEAKER_ALLOC_CODE
);

  // ---------------------------------------------------------------------
  // implemented-bit mask per address
  // ---------------------------------------------------------------------
  // storing through the mask keeps reserved bits zero and stops a change
  // in a reserved bit from raising a spurious change flag
  function [7:0] field_mask;
    input [7:0] addr;
    begin
      if (addr == `REG_AVI_FORMAT) begin
        field_mask = `MASK_AVI_FORMAT;
      end else if (addr == `REG_SCALING) begin
        field_mask = `MASK_SCALING;
      end else if (addr == `REG_VIDEO_CODE) begin
        field_mask = `MASK_VIDEO_CODE;
      end else if (addr == `REG_PIXEL_REPEAT) begin
        field_mask = `MASK_PIXEL_REPEAT;
      end else if (addr == `REG_AUDIO_CODING) begin
        field_mask = `MASK_AUDIO_CODING;
      end else if (addr == `REG_AUDIO_RATE) begin
        field_mask = `MASK_AUDIO_RATE;
      end else if (addr == `REG_LEVEL_SHIFT) begin
        field_mask = `MASK_LEVEL_SHIFT;
      end else begin
        field_mask = `MASK_FULL;
      end
    end
  endfunction

  // ---------------------------------------------------------------------
  // stored bytes
  // ---------------------------------------------------------------------
  wire [7:0]            cell_value [0:`BANK_BYTES-1];
  wire [`BANK_BYTES-1:0] cell_changed;
  wire                  pkt_in_bank;
  wire [7:0]            pkt_index;
  wire [7:0]            pkt_data_masked;

  assign pkt_in_bank = (I_PKT_ADDR >= `BANK_BASE) &&
                       (I_PKT_ADDR <= `BANK_LAST) &&
                       (I_PKT_ADDR[2:0] != `FLAG_ADDR_LOW);
  assign pkt_index       = I_PKT_ADDR - `BANK_BASE;
  assign pkt_data_masked = I_PKT_DATA & field_mask(I_PKT_ADDR);

  // flag slots hold no byte and read from the shared flags instead
  genvar gi;
  generate
    for (gi = 0; gi < `BANK_BYTES; gi = gi + 1) begin : g_cell
      if ((gi % 8) == 7) begin : g_flag_slot
        assign cell_value[gi]   = `FIELD_RESET;
        assign cell_changed[gi] = 1'b0;
      end else begin : g_byte
        // sized copy of the slot number for the address compare
        localparam [7:0] CELL_INDEX = gi;
        infoframe_byte_cell #(
          .WIDTH (8)
        ) u_cell (
          .i_clk     (I_CLOCK),
          .i_arst_n  (I_ARST_N),
          .i_load    (I_PKT_WR && pkt_in_bank &&
                      (pkt_index == CELL_INDEX)),
          .i_data    (pkt_data_masked),
          .o_value   (cell_value[gi]),
          .o_changed (cell_changed[gi])
        );
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // change flags
  // ---------------------------------------------------------------------
  wire [6:0] flag_set;
  wire [6:0] flags;
  wire       flag_read;

  // the differing byte is stored on the same edge that sets its flag
  assign flag_set = ((|cell_changed) ?
                     (7'h01 << I_PKT_KIND) : 7'h00) | I_EXT_CHANGE;
  // any mirrored slot in the upper half clears the one shared register
  assign flag_read = I_RD_STROBE && I_RD_ADDR[7] &&
                     (I_RD_ADDR[2:0] == `FLAG_ADDR_LOW);

  infoframe_flag_bank #(
    .WIDTH (`FLAG_COUNT)
  ) u_flags (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_set    (flag_set),
    .i_clear  (flag_read),
    .o_flags  (flags)
  );

  // ---------------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------------
  reg  [7:0] rd_data_next;
  wire [7:0] rd_index;

  assign rd_index = I_RD_ADDR - `BANK_BASE;

  // addresses outside the bank answer zero rather than stale data, except the upper-half flag mirrors, which answer the flags
  always @* begin
    if (!I_RD_ADDR[7]) begin
      rd_data_next = `MASK_NONE;
    end else if (I_RD_ADDR[2:0] == `FLAG_ADDR_LOW) begin
      rd_data_next = {1'b0, flags};
    end else if (I_RD_ADDR <= `BANK_LAST) begin
      rd_data_next = cell_value[rd_index[4:0]];
    end else begin
      rd_data_next = `MASK_NONE;
    end
  end

  // answer lands one edge after the strobe and stands for that cycle
  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RD_DATA  <= `FIELD_RESET;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_RD_STROBE;
      if (I_RD_STROBE) begin
        O_RD_DATA <= rd_data_next;
      end
    end
  end

  // ---------------------------------------------------------------------
  // decoded video fields
  // ---------------------------------------------------------------------
  wire [15:0] top_end;
  wire [15:0] bottom_start;
  wire [15:0] left_end;
  wire [15:0] right_start;

  // byte pairs joined high over low
  assign top_end      = {cell_value[8],  cell_value[6]};
  assign bottom_start = {cell_value[10], cell_value[9]};
  assign left_end     = {cell_value[12], cell_value[11]};
  assign right_start  = {cell_value[14], cell_value[13]};

  // outputs lag the stored bytes by one edge to stay registered
  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_NEW_DATA_FLAGS     <= `FLAGS_RESET;
      O_ASPECT_CODE        <= 2'h0;
      O_ACTIVE_FORMAT_CODE <= 4'h0;
      O_SCALING_CODE       <= 2'h0;
      O_VIDEO_FORMAT_CODE  <= 7'h00;
      O_PIXEL_SEND_COUNT   <= 5'h01;
      O_TOP_BAR_END        <= 16'h0000;
      O_BOTTOM_BAR_START   <= 16'h0000;
      O_LEFT_BAR_END       <= 16'h0000;
      O_RIGHT_BAR_START    <= 16'h0000;
      O_TOP_BAR_PRESENT    <= 1'b0;
      O_BOTTOM_BAR_PRESENT <= 1'b0;
      O_LEFT_BAR_PRESENT   <= 1'b0;
      O_RIGHT_BAR_PRESENT  <= 1'b0;
    end else begin
      O_NEW_DATA_FLAGS     <= flags;
      O_ASPECT_CODE        <= cell_value[2][5:4];
      O_ACTIVE_FORMAT_CODE <= cell_value[2][3:0];
      O_SCALING_CODE       <= cell_value[3][1:0];
      O_VIDEO_FORMAT_CODE  <= cell_value[4][6:0];
      O_PIXEL_SEND_COUNT   <= {1'b0, cell_value[5][3:0]} + 5'h01;
      O_TOP_BAR_END        <= top_end;
      O_BOTTOM_BAR_START   <= bottom_start;
      O_LEFT_BAR_END       <= left_end;
      O_RIGHT_BAR_START    <= right_start;
      O_TOP_BAR_PRESENT    <= (top_end != 16'h0000);
      O_BOTTOM_BAR_PRESENT <= (bottom_start <= I_DISPLAY_LINES);
      O_LEFT_BAR_PRESENT   <= (left_end != 16'h0000);
      O_RIGHT_BAR_PRESENT  <= (right_start <= I_DISPLAY_PIXELS);
    end
  end

  // ---------------------------------------------------------------------
  // decoded audio fields
  // ---------------------------------------------------------------------
  wire [2:0] chan_code;

  assign chan_code = cell_value[17][2:0];

  // zero channel code defers to the stream header, reported as zero
  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_AUDIO_CODING_CODE  <= 4'h0;
      O_CHANNEL_COUNT      <= 4'h0;
      O_MAX_BIT_RATE_KHZ   <= 11'h000;
      O_SPEAKER_ALLOC_CODE <= 8'h00;
    end else begin
      O_AUDIO_CODING_CODE  <= cell_value[17][7:4];
      O_CHANNEL_COUNT      <= (chan_code == 3'h0) ? 4'h0 :
                              ({1'b0, chan_code} + 4'h1);
      O_MAX_BIT_RATE_KHZ   <= {cell_value[19], 3'h0};
      O_SPEAKER_ALLOC_CODE <= cell_value[20];
    end
  end

endmodule

// ---- infoframe_regs.vh ----
// register map, field layout and reset values of the information frame bank
`ifndef INFOFRAME_REGS_VH
`define INFOFRAME_REGS_VH

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define BANK_BASE          8'h80
`define BANK_LAST          8'h95
`define BANK_BYTES         22
`define FLAG_ADDR_LOW      3'h7
`define REG_AVI_VERSION    8'h80
`define REG_AVI_FORMAT     8'h81
`define REG_ASPECT         8'h82
`define REG_SCALING        8'h83
`define REG_VIDEO_CODE     8'h84
`define REG_PIXEL_REPEAT   8'h85
`define REG_TOP_LOW        8'h86
`define REG_FLAGS_A        8'h87
`define REG_TOP_HIGH       8'h88
`define REG_BOTTOM_LOW     8'h89
`define REG_BOTTOM_HIGH    8'h8A
`define REG_LEFT_LOW       8'h8B
`define REG_LEFT_HIGH      8'h8C
`define REG_RIGHT_LOW      8'h8D
`define REG_RIGHT_HIGH     8'h8E
`define REG_FLAGS_B        8'h8F
`define REG_AUDIO_VERSION  8'h90
`define REG_AUDIO_CODING   8'h91
`define REG_AUDIO_RATE     8'h92
`define REG_MAX_BIT_RATE   8'h93
`define REG_SPEAKER        8'h94
`define REG_LEVEL_SHIFT    8'h95

// ----------------------------------------------------------------------
// implemented bits per register; the rest read as zero
// ----------------------------------------------------------------------
`define MASK_FULL          8'hFF
`define MASK_AVI_FORMAT    8'h7F
`define MASK_SCALING       8'h03
`define MASK_VIDEO_CODE    8'h7F
`define MASK_PIXEL_REPEAT  8'h0F
`define MASK_AUDIO_CODING  8'hF7
`define MASK_AUDIO_RATE    8'h1F
`define MASK_LEVEL_SHIFT   8'hF8
`define MASK_FLAGS         8'h7F
`define MASK_NONE          8'h00

// ----------------------------------------------------------------------
// change flag bits, reset values, scale factors
// ----------------------------------------------------------------------
`define FLAG_COUNT         7
`define FLAG_VIDEO         0
`define FLAG_AUDIO         1
`define FLAG_SOURCE        2
`define FLAG_COMPRESSED    3
`define FLAG_PROTECT       4
`define FLAG_CODE1         5
`define FLAG_CODE2         6
`define FIELD_RESET        8'h00
`define FLAGS_RESET        7'h00
`define BIT_RATE_STEP_KHZ  8

`endif

// ---- infoframe_byte_cell.v ----
// one stored frame byte with change detection against the new value
`timescale 1ns/1ps
module infoframe_byte_cell #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,
  input  wire             i_arst_n,
  input  wire             i_load,
  input  wire [WIDTH-1:0] i_data,
  output wire [WIDTH-1:0] o_value,
  output wire             o_changed
);

  reg [WIDTH-1:0] value_reg;

  // only a differing byte counts as a change; equal resends stay silent
  assign o_changed = i_load && (i_data != value_reg);
  assign o_value   = value_reg;

  // -------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      value_reg <= {WIDTH{1'b0}};
    end else if (o_changed) begin
      value_reg <= i_data;
    end
  end

endmodule

// ---- infoframe_flag_bank.v ----
// shared change flags: set by frame updates, cleared by a host read
`timescale 1ns/1ps
module infoframe_flag_bank #(
  parameter WIDTH = 7
) (
  input  wire             i_clk,
  input  wire             i_arst_n,
  input  wire [WIDTH-1:0] i_set,
  input  wire             i_clear,
  output wire [WIDTH-1:0] o_flags
);

  reg [WIDTH-1:0] flags_reg;
  reg [WIDTH-1:0] flags_next;

  // a set arriving with the clearing read survives, so no change is lost
  always @* begin
    flags_next = (i_clear ? {WIDTH{1'b0}} : flags_reg) | i_set;
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flags_reg <= {WIDTH{1'b0}};
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

endmodule

// ---- infoframe_bank_monitor.sv ----
// concurrent checks on the port behaviour of the information frame bank
`timescale 1ns/1ps
module infoframe_bank_monitor (
  input wire        I_CLOCK,
  input wire        I_ARST_N,
  input wire        I_RD_STROBE,
  input wire [7:0]  I_RD_ADDR,
  input wire        I_PKT_WR,
  input wire [7:0]  I_PKT_ADDR,
  input wire [7:0]  I_PKT_DATA,
  input wire [6:0]  I_EXT_CHANGE,
  input wire [15:0] I_DISPLAY_LINES,
  input wire [7:0]  O_RD_DATA,
  input wire        O_RD_VALID,
  input wire [6:0]  O_NEW_DATA_FLAGS,
  input wire [4:0]  O_PIXEL_SEND_COUNT,
  input wire [15:0] O_TOP_BAR_END,
  input wire [15:0] O_BOTTOM_BAR_START,
  input wire        O_TOP_BAR_PRESENT,
  input wire        O_BOTTOM_BAR_PRESENT,
  input wire [3:0]  O_CHANNEL_COUNT,
  input wire [10:0] O_MAX_BIT_RATE_KHZ
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  // expectations worked out from the byte on the parser port
  wire        flag_rd = I_RD_STROBE && I_RD_ADDR[7] && (I_RD_ADDR[2:0] == 3'h7);
  wire        quiet = !I_PKT_WR && (I_EXT_CHANGE == 7'h00);
  wire [4:0]  rep_exp = {1'b0, I_PKT_DATA[3:0]} + 5'h01;
  wire [3:0]  cc_exp = (I_PKT_DATA[2:0] == 3'h0) ? 4'h0
                       : {1'b0, I_PKT_DATA[2:0]} + 4'h1;
  wire [10:0] rate_exp = {I_PKT_DATA, 3'h0};

  property p_valid;
    $past(I_ARST_N) |-> O_RD_VALID == $past(I_RD_STROBE);
  endproperty
  a_valid: assert property (p_valid)
    else $error("read answer not one cycle after strobe");
  property p_flag_data;
    flag_rd |=> O_RD_DATA == {1'b0, O_NEW_DATA_FLAGS};
  endproperty
  a_flag_data: assert property (p_flag_data)
    else $error("mirrored flag read differs from flags");
  property p_flag_clear;
    flag_rd && quiet |-> ##2 O_NEW_DATA_FLAGS == 7'h00;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flags not cleared by read");
  property p_ext_set;
    I_EXT_CHANGE != 7'h00 |-> ##2
      (O_NEW_DATA_FLAGS & $past(I_EXT_CHANGE, 2)) == $past(I_EXT_CHANGE, 2);
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("change pulse did not set its flag");
  property p_repeat;
    I_PKT_WR && I_PKT_ADDR == 8'h85 |-> ##2
      O_PIXEL_SEND_COUNT == $past(rep_exp, 2);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("pixel send count wrong");
  property p_channels;
    I_PKT_WR && I_PKT_ADDR == 8'h91 |-> ##2 O_CHANNEL_COUNT == $past(cc_exp, 2);
  endproperty
  a_channels: assert property (p_channels)
    else $error("channel count wrong");
  property p_rate;
    I_PKT_WR && I_PKT_ADDR == 8'h93 |-> ##2
      O_MAX_BIT_RATE_KHZ == $past(rate_exp, 2);
  endproperty
  a_rate: assert property (p_rate)
    else $error("bit rate scaling wrong");
  property p_top;
    O_TOP_BAR_PRESENT == (O_TOP_BAR_END != 16'h0000);
  endproperty
  a_top: assert property (p_top)
    else $error("top bar flag disagrees with line");
  property p_bottom;
    $past(I_ARST_N) |->
      O_BOTTOM_BAR_PRESENT == (O_BOTTOM_BAR_START <= $past(I_DISPLAY_LINES));
  endproperty
  a_bottom: assert property (p_bottom)
    else $error("bottom bar flag disagrees with line");
endmodule

// ---- infoframe_source_model.sv ----
// behavioural frame source: parsed bytes and change pulses
`timescale 1ns/1ps
module infoframe_source_model (
  input  wire        i_clk,
  output logic       o_wr,
  output logic [7:0] o_addr,
  output logic [7:0] o_data,
  output logic [2:0] o_kind,
  output logic [6:0] o_ext
);
  initial begin
    o_wr = 1'b0;
    o_addr = 8'h00;
    o_data = 8'h00;
    o_kind = 3'h0;
    o_ext = 7'h00;
  end
  // one byte held across exactly one taking edge
  task send(input [7:0] addr, input [7:0] data, input [2:0] kind);
    @(posedge i_clk);
    #1;
    o_wr = 1'b1;
    o_addr = addr;
    o_data = data;
    o_kind = kind;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    // released lines show the inverse so stale values never look valid
    o_addr = ~addr;
    o_data = ~data;
  endtask
  task pulse(input [6:0] bits);
    @(posedge i_clk);
    #1;
    o_ext = bits;
    @(posedge i_clk);
    #1;
    o_ext = 7'h00;
  endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the information frame register bank
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        rd_stb = 1'b0;
  logic [7:0]  rd_addr = 8'h00;
  logic [15:0] lines = 16'h0438;
  logic [15:0] pixels = 16'h0780;
  wire         pkt_wr, rd_valid, top_p, bot_p, left_p, right_p;
  wire [7:0]   pkt_addr, pkt_data, rd_data, spk;
  wire [2:0]   pkt_kind;
  wire [6:0]   ext, flags, vcode;
  wire [1:0]   aspect, scale;
  wire [3:0]   afd, coding, chans;
  wire [4:0]   sends;
  wire [15:0]  top, bottom, left, right;
  wire [10:0]  rate;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // rows: address, byte sent, value read back; first twelve are video
  logic [7:0] row_addr [16] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h88,
    8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90, 8'h91, 8'h93, 8'h94};
  logic [7:0] row_data [16] = '{8'h29, 8'hFF, 8'h90, 8'hF8, 8'h34, 8'h12,
    8'h00, 8'h05, 8'h01, 8'h00, 8'h00, 8'h08, 8'hA5, 8'hF3, 8'h08, 8'h1F};
  logic [7:0] row_exp [16] = '{8'h29, 8'h03, 8'h10, 8'h08, 8'h34, 8'h12,
    8'h00, 8'h05, 8'h01, 8'h00, 8'h00, 8'h08, 8'hA5, 8'hF3, 8'h08, 8'h1F};

  always #5 clk = ~clk;

  infoframe_source_model src (.i_clk(clk), .o_wr(pkt_wr), .o_addr(pkt_addr),
    .o_data(pkt_data), .o_kind(pkt_kind), .o_ext(ext));

  infoframe_register_bank dut (.I_CLOCK(clk), .I_ARST_N(arst_n),
    .I_RD_STROBE(rd_stb), .I_RD_ADDR(rd_addr), .I_PKT_WR(pkt_wr),
    .I_PKT_ADDR(pkt_addr), .I_PKT_DATA(pkt_data), .I_PKT_KIND(pkt_kind),
    .I_EXT_CHANGE(ext), .I_DISPLAY_LINES(lines), .I_DISPLAY_PIXELS(pixels),
    .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .O_NEW_DATA_FLAGS(flags),
    .O_ASPECT_CODE(aspect), .O_ACTIVE_FORMAT_CODE(afd),
    .O_SCALING_CODE(scale), .O_VIDEO_FORMAT_CODE(vcode),
    .O_PIXEL_SEND_COUNT(sends), .O_TOP_BAR_END(top),
    .O_BOTTOM_BAR_START(bottom), .O_LEFT_BAR_END(left),
    .O_RIGHT_BAR_START(right), .O_TOP_BAR_PRESENT(top_p),
    .O_BOTTOM_BAR_PRESENT(bot_p), .O_LEFT_BAR_PRESENT(left_p),
    .O_RIGHT_BAR_PRESENT(right_p), .O_AUDIO_CODING_CODE(coding),
    .O_CHANNEL_COUNT(chans), .O_MAX_BIT_RATE_KHZ(rate),
    .O_SPEAKER_ALLOC_CODE(spk));

  task chk(input [15:0] got, input [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one read: strobe held for one taking edge, answer sampled after it
  task rd(input [7:0] a);
    @(posedge clk);
    #1;
    rd_stb = 1'b1;
    rd_addr = a;
    @(posedge clk);
    #1;
    rd_stb = 1'b0;
    chk(16'(rd_valid), 16'h0001);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang is cut short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    // zero rows equal the reset copy, so they must raise no flag
    for (int i = 0; i < 16; i++) begin
      src.send(row_addr[i], row_data[i], (i < 12) ? 3'h0 : 3'h1);
      rd(row_addr[i]);
      chk(16'(rd_data), 16'(row_exp[i]));
      rd(8'h87 + 8'(i * 8));
      chk(16'(rd_data), (row_exp[i] == 8'h00) ? 16'h0000
          : ((i < 12) ? 16'h0001 : 16'h0002));
    end
    $display("table rows done");
    chk(16'(aspect), 16'h0002);
    chk(16'(afd), 16'h0009);
    chk(16'(scale), 16'h0003);
    chk(16'(vcode), 16'h0010);
    chk(16'(sends), 16'h0009);
    chk(top, 16'h1234);
    chk(16'(top_p), 16'h0001);
    chk(bottom, 16'h0500);
    chk(16'(bot_p), 16'h0000);
    chk(left, 16'h0001);
    chk(16'(left_p), 16'h0001);
    chk(16'(right_p), 16'h0000);
    chk(right, 16'h0800);
    chk(16'(coding), 16'h000F);
    chk(16'(chans), 16'h0004);
    chk(16'(rate), 16'h0040);
    chk(16'(spk), 16'h001F);
    $display("decoded fields done");
    // equal contents again: no flag; then every flag through a mirror
    src.send(8'h84, 8'h90, 3'h0);
    rd(8'h8F);
    chk(16'(rd_data), 16'h0000);
    src.pulse(7'h7F);
    rd(8'h97);
    chk(16'(rd_data), 16'h007F);
    rd(8'hFF);
    chk(16'(rd_data), 16'h0000);
    rd(8'h40);
    chk(16'(rd_data), 16'h0000);
    // a parsed byte of the last frame kind reaches the top flag bit
    src.send(8'h92, 8'hFF, 3'h6);
    rd(8'h92);
    chk(16'(rd_data), 16'h001F);
    rd(8'hB7);
    chk(16'(rd_data), 16'h0040);
    $display("flags and unmapped done");
    // counts equal to the display size still leave a bar
    lines = 16'h0500;
    pixels = 16'h0800;
    repeat (3) @(posedge clk);
    #1;
    chk(16'(bot_p), 16'h0001);
    chk(16'(right_p), 16'h0001);
    $display("bar boundary done");
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    rd(8'h84);
    chk(16'(rd_data), 16'h0000);
    chk(16'(sends), 16'h0001);
    $display("mid-run reset done");
    complete_run();
  end
endmodule

bind infoframe_register_bank infoframe_bank_monitor mon (
  .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_RD_STROBE(I_RD_STROBE),
  .I_RD_ADDR(I_RD_ADDR), .I_PKT_WR(I_PKT_WR), .I_PKT_ADDR(I_PKT_ADDR),
  .I_PKT_DATA(I_PKT_DATA), .I_EXT_CHANGE(I_EXT_CHANGE),
  .I_DISPLAY_LINES(I_DISPLAY_LINES), .O_RD_DATA(O_RD_DATA),
  .O_RD_VALID(O_RD_VALID), .O_NEW_DATA_FLAGS(O_NEW_DATA_FLAGS),
  .O_PIXEL_SEND_COUNT(O_PIXEL_SEND_COUNT), .O_TOP_BAR_END(O_TOP_BAR_END),
  .O_BOTTOM_BAR_START(O_BOTTOM_BAR_START),
  .O_TOP_BAR_PRESENT(O_TOP_BAR_PRESENT),
  .O_BOTTOM_BAR_PRESENT(O_BOTTOM_BAR_PRESENT),
  .O_CHANNEL_COUNT(O_CHANNEL_COUNT), .O_MAX_BIT_RATE_KHZ(O_MAX_BIT_RATE_KHZ));
